/* File: hw/ubeirq_cfg.svh */
`ifndef UBEIRQ_CFG_SVH
`define UBEIRQ_CFG_SVH
// Functional notes
// - an endpoint event sets its flag bit in its direction's flag register.
// - reading the source register clears the flag whose code that read returned.
// - writing one clears a flag bit, writing zero leaves it alone.
// - all flag and enable bits reset to zero.
// - endpoints 1 to 7 request when flag and enable are both set.
// - a cleared enable bit blocks requests for that endpoint.
// - endpoint 0 also needs the gate bit of its config register.
// - separate OUT and IN registers, bit n serves endpoint n.
// - IN flag sets when a packet leaves, OUT flag when one arrives.
// - all requests merge onto one interrupt line with a source code.
// - OUT0 has the best code, then IN0; lower codes win.

// register byte offsets on the bus
`define UBEIRQ_OFS_OUT_FLAGS 12'h000
`define UBEIRQ_OFS_IN_FLAGS 12'h004
`define UBEIRQ_OFS_OUT_EN 12'h008
`define UBEIRQ_OFS_IN_EN 12'h00C
`define UBEIRQ_OFS_OUT_CFG0 12'h010
`define UBEIRQ_OFS_IN_CFG0 12'h014
`define UBEIRQ_OFS_SRC 12'h018

// field positions and reset values
`define UBEIRQ_GATE_BIT 0
`define UBEIRQ_FLAG_RST 8'h00
`define UBEIRQ_EN_RST 8'h00
`define UBEIRQ_GATE_RST 1'b0

// source codes
`define UBEIRQ_CODE_NONE 8'h00
`define UBEIRQ_CODE_OUT0 8'h02
`define UBEIRQ_CODE_IN0 8'h04
`define UBEIRQ_CODE_OUT_BASE 8'h10
`define UBEIRQ_CODE_IN_BASE 8'h20
`endif

/* File: hw/ubeirq_flag_bank.sv */
`timescale 1ns/100ps
module ubeirq_flag_bank #(
  parameter int NUM_EP = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NUM_EP-1:0] set_vec,
  input wire logic [NUM_EP-1:0] w1c_vec,
  input wire logic [NUM_EP-1:0] rdclr_vec,
  output logic [NUM_EP-1:0] flag_q
);
  logic [NUM_EP-1:0] flag_d;

  // refuse endpoint counts that the eight-bit flag registers cannot hold
  if (NUM_EP < 1 || NUM_EP > 8)
  begin : g_bad_num_ep
    $error("flag bank serves 1 to 8 endpoints");
  end

  // set wins over either clear so an event in the clearing cycle is kept
  assign flag_d = (flag_q & ~(w1c_vec | rdclr_vec)) | set_vec;

  // flags start clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      flag_q <= '0;
    else
      flag_q <= flag_d;
  end

  AST_SET_WINS: assert property (@(posedge clk) disable iff (sys_rst)
    (|set_vec) |=> ((flag_q & $past(set_vec)) == $past(set_vec)))
    else $error("flag lost its set event");
endmodule : ubeirq_flag_bank

/* File: hw/ubeirq_pkg.sv */
`include "ubeirq_cfg.svh"
package ubeirq_pkg;
  typedef logic [7:0] ubeirq_vec_t;
  typedef logic [7:0] ubeirq_code_t;
  typedef enum logic {UBEIRQ_DIR_OUT, UBEIRQ_DIR_IN} ubeirq_dir_t;

  // code of endpoint ep in direction dir; endpoint n>0 sits at base plus 2n
  function automatic ubeirq_code_t ubeirq_ep_code(input ubeirq_dir_t dir, input logic [2:0] ep);
    ubeirq_code_t base;
    base = (dir == UBEIRQ_DIR_OUT) ? `UBEIRQ_CODE_OUT_BASE : `UBEIRQ_CODE_IN_BASE;
    if (ep == 3'h0)
    begin
      return (dir == UBEIRQ_DIR_OUT) ? `UBEIRQ_CODE_OUT0 : `UBEIRQ_CODE_IN0;
    end
    return base + {4'h0, ep, 1'b0};
  endfunction : ubeirq_ep_code
endpackage : ubeirq_pkg

/* File: hw/ubeirq_src_arb.sv */
`timescale 1ns/100ps
`include "ubeirq_cfg.svh"
module ubeirq_src_arb #(
  parameter int NUM_EP = 8
) (
  input wire logic [NUM_EP-1:0] out_req,
  input wire logic [NUM_EP-1:0] in_req,
  output ubeirq_pkg::ubeirq_code_t code
);
  import ubeirq_pkg::*;

  // the code function takes a three-bit endpoint number
  if (NUM_EP < 1 || NUM_EP > 8)
  begin : g_bad_num_ep
    $error("arbiter serves 1 to 8 endpoints");
  end

  // walk from the weakest source up so the best pending one is left standing
  always_comb
  begin
    code = `UBEIRQ_CODE_NONE;
    for (int i = NUM_EP - 1; i >= 1; i--)
    begin
      if (in_req[i])
        code = ubeirq_ep_code(UBEIRQ_DIR_IN, 3'(i));
    end
    for (int i = NUM_EP - 1; i >= 1; i--)
    begin
      if (out_req[i])
        code = ubeirq_ep_code(UBEIRQ_DIR_OUT, 3'(i));
    end
    if (in_req[0])
      code = `UBEIRQ_CODE_IN0;
    if (out_req[0])
      code = `UBEIRQ_CODE_OUT0;
  end
endmodule : ubeirq_src_arb

/* File: hw/ubeirq_top.sv */
`timescale 1ns/100ps
`include "ubeirq_cfg.svh"
module ubeirq_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ubeirq_pkg::ubeirq_vec_t out_pkt_in_evt,
  input wire ubeirq_pkg::ubeirq_vec_t in_pkt_out_evt,
  output logic usb_irq
);
  import ubeirq_pkg::*;

  localparam int NUM_EP = 8;

  logic setup_ph;
  logic access_ph;
  logic wr_fire;
  logic rd_fire;
  logic hit_out_flags;
  logic hit_in_flags;
  logic hit_out_en;
  logic hit_in_en;
  logic hit_out_cfg;
  logic hit_in_cfg;
  logic hit_src;
  logic mapped;
  ubeirq_vec_t out_flag_q;
  ubeirq_vec_t in_flag_q;
  ubeirq_vec_t out_en_q;
  ubeirq_vec_t in_en_q;
  logic out_gate_q;
  logic in_gate_q;
  ubeirq_vec_t out_w1c;
  ubeirq_vec_t in_w1c;
  ubeirq_vec_t out_rdclr;
  ubeirq_vec_t in_rdclr;
  ubeirq_vec_t out_req;
  ubeirq_vec_t in_req;
  ubeirq_code_t src_code;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic src_rd_q;
  logic [31:0] out_cfg_word;
  logic [31:0] in_cfg_word;

  // bus phases; the slave never stretches the access phase
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_fire = access_ph & pwrite;
  assign rd_fire = access_ph & ~pwrite;
  assign pready = access_ph;
  assign pslverr = access_ph & pslverr_q;
  assign prdata = prdata_q;

  // address decode, one aligned word per register
  assign hit_out_flags = (paddr == `UBEIRQ_OFS_OUT_FLAGS);
  assign hit_in_flags = (paddr == `UBEIRQ_OFS_IN_FLAGS);
  assign hit_out_en = (paddr == `UBEIRQ_OFS_OUT_EN);
  assign hit_in_en = (paddr == `UBEIRQ_OFS_IN_EN);
  assign hit_out_cfg = (paddr == `UBEIRQ_OFS_OUT_CFG0);
  assign hit_in_cfg = (paddr == `UBEIRQ_OFS_IN_CFG0);
  assign hit_src = (paddr == `UBEIRQ_OFS_SRC);
  assign mapped = hit_out_flags | hit_in_flags | hit_out_en | hit_in_en | hit_out_cfg | hit_in_cfg | hit_src;

  // write-one-to-clear strobes; the reserved upper three bytes are simply dropped
  assign out_w1c = (wr_fire & hit_out_flags) ? pwdata[7:0] : 8'h00;
  assign in_w1c = (wr_fire & hit_in_flags) ? pwdata[7:0] : 8'h00;

  // a source read clears the flag whose code was latched in its setup cycle,
  // so a flag that rises between setup and access is not cleared unseen
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_rdclr
      assign out_rdclr[g] = rd_fire & src_rd_q & (prdata_q[7:0] == ubeirq_ep_code(UBEIRQ_DIR_OUT, 3'(g)));
      assign in_rdclr[g] = rd_fire & src_rd_q & (prdata_q[7:0] == ubeirq_ep_code(UBEIRQ_DIR_IN, 3'(g)));
    end
  endgenerate

  // OUT flags follow packets moved into the buffer
  ubeirq_flag_bank #(
    .NUM_EP(NUM_EP)
  ) u_out_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_vec(out_pkt_in_evt),
    .w1c_vec(out_w1c),
    .rdclr_vec(out_rdclr),
    .flag_q(out_flag_q)
  );

  // IN flags follow packets leaving the buffer
  ubeirq_flag_bank #(
    .NUM_EP(NUM_EP)
  ) u_in_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_vec(in_pkt_out_evt),
    .w1c_vec(in_w1c),
    .rdclr_vec(in_rdclr),
    .flag_q(in_flag_q)
  );

  // enable storage, plain read/write with no side effect
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_en_q <= `UBEIRQ_EN_RST;
      in_en_q <= `UBEIRQ_EN_RST;
    end
    else
    begin
      if (wr_fire & hit_out_en)
        out_en_q <= pwdata[7:0];
      if (wr_fire & hit_in_en)
        in_en_q <= pwdata[7:0];
    end
  end

  // endpoint zero gate bits held in their config words
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_gate_q <= `UBEIRQ_GATE_RST;
      in_gate_q <= `UBEIRQ_GATE_RST;
    end
    else
    begin
      if (wr_fire & hit_out_cfg)
        out_gate_q <= pwdata[`UBEIRQ_GATE_BIT];
      if (wr_fire & hit_in_cfg)
        in_gate_q <= pwdata[`UBEIRQ_GATE_BIT];
    end
  end

  // request gating: endpoint 0 needs its extra gate, the rest only the enable
  assign out_req = out_flag_q & out_en_q & {7'h7F, out_gate_q};
  assign in_req = in_flag_q & in_en_q & {7'h7F, in_gate_q};

  // one interrupt line for every endpoint source
  assign usb_irq = (|out_req) | (|in_req);

  ubeirq_src_arb #(
    .NUM_EP(NUM_EP)
  ) u_arb (
    .out_req(out_req),
    .in_req(in_req),
    .code(src_code)
  );

  // read data; reserved bits read as zero
  assign out_cfg_word = {31'h00000000, out_gate_q} << `UBEIRQ_GATE_BIT;
  assign in_cfg_word = {31'h00000000, in_gate_q} << `UBEIRQ_GATE_BIT;
  assign rdata_d = hit_out_flags ? {24'h000000, out_flag_q} :
                   hit_in_flags ? {24'h000000, in_flag_q} :
                   hit_out_en ? {24'h000000, out_en_q} :
                   hit_in_en ? {24'h000000, in_en_q} :
                   hit_out_cfg ? out_cfg_word :
                   hit_in_cfg ? in_cfg_word :
                   hit_src ? {24'h000000, src_code} :
                   32'h00000000;

  // read data is captured in the setup cycle so it comes from a flop
  // and still answers with no wait state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      src_rd_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_q <= pwrite ? 32'h00000000 : rdata_d;
      pslverr_q <= ~mapped;
      src_rd_q <= hit_src & ~pwrite;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_OUT_SET: assert property ((|out_pkt_in_evt) |=> ((out_flag_q & $past(out_pkt_in_evt)) == $past(out_pkt_in_evt)))
    else $error("out flag did not set on packet arrival");

  AST_IN_SET: assert property ((|in_pkt_out_evt) |=> ((in_flag_q & $past(in_pkt_out_evt)) == $past(in_pkt_out_evt)))
    else $error("in flag did not set on packet departure");

  AST_SRC_RDCLR: assert property ((rd_fire && src_rd_q && prdata_q[7:0] == `UBEIRQ_CODE_OUT0 && !out_pkt_in_evt[0])
    |=> !out_flag_q[0])
    else $error("source read did not clear out0 flag");

  AST_SRC_RDCLR_IN: assert property ((rd_fire && src_rd_q && prdata_q[7:0] == 8'h22 && !in_pkt_out_evt[1])
    |=> !in_flag_q[1])
    else $error("source read did not clear in1 flag");

  AST_W1C: assert property ((wr_fire && hit_out_flags)
    |=> ((out_flag_q & $past(pwdata[7:0]) & ~$past(out_pkt_in_evt)) == 8'h00))
    else $error("write one did not clear flag");

  AST_W0_KEEP: assert property ((wr_fire && hit_in_flags)
    |=> ((in_flag_q & ~$past(pwdata[7:0])) == (($past(in_flag_q) | $past(in_pkt_out_evt)) & ~$past(pwdata[7:0]))))
    else $error("write zero changed a flag");

  AST_RST_VAL: assert property (disable iff (1'b0) $fell(sys_rst)
    |-> (out_flag_q == 8'h00 && in_flag_q == 8'h00 && out_en_q == 8'h00 && in_en_q == 8'h00))
    else $error("flags or enables not zero after reset");

  AST_EP_REQ: assert property ((|(out_flag_q[7:1] & out_en_q[7:1])) || (|(in_flag_q[7:1] & in_en_q[7:1]))
    |-> usb_irq)
    else $error("enabled pending endpoint raised no request");

  AST_NO_EN: assert property ((out_en_q == 8'h00 && in_en_q == 8'h00) |-> !usb_irq)
    else $error("request with all enables clear");

  AST_EP0_GATE: assert property ((out_en_q[7:1] == 7'h00 && in_en_q[7:1] == 7'h00 && !out_gate_q && !in_gate_q)
    |-> !usb_irq)
    else $error("endpoint zero requested without its gate");

  AST_SEP_DIR: assert property ((wr_fire && hit_out_flags) |=> ((in_flag_q & $past(in_flag_q)) == $past(in_flag_q)))
    else $error("out flag write touched in flags");

  AST_EN_RW: assert property ((setup_ph && hit_in_en && !pwrite)
    |=> prdata_q[7:0] == $past(in_en_q))
    else $error("enable did not read back");

  AST_EN_STORE: assert property ((wr_fire && hit_in_en) |=> in_en_q == $past(pwdata[7:0]))
    else $error("enable write not stored");

  AST_SET_NO_EN: assert property ((out_en_q[1] == 1'b0 && out_pkt_in_evt[1]) |=> out_flag_q[1])
    else $error("disabled endpoint flag did not set");

  AST_SRC_OUT0: assert property ((setup_ph && hit_src && !pwrite && out_req[0])
    |=> prdata_q[7:0] == `UBEIRQ_CODE_OUT0)
    else $error("out0 did not win arbitration");

  AST_SRC_IN0: assert property ((setup_ph && hit_src && !pwrite && !out_req[0] && in_req[0])
    |=> prdata_q[7:0] == `UBEIRQ_CODE_IN0)
    else $error("in0 did not beat the other endpoints");

  AST_IRQ_CODE: assert property ((setup_ph && hit_src && !pwrite && usb_irq)
    |=> prdata_q[7:0] != `UBEIRQ_CODE_NONE)
    else $error("pending request read as no source");

  // the other direction of the clear paths
  AST_IN_W1C: assert property ((wr_fire && hit_in_flags)
    |=> ((in_flag_q & $past(pwdata[7:0]) & ~$past(in_pkt_out_evt)) == 8'h00))
    else $error("write one did not clear in flag");

  AST_OUT_W0_KEEP: assert property ((wr_fire && hit_out_flags)
    |=> ((out_flag_q & ~$past(pwdata[7:0])) ==
         (($past(out_flag_q) | $past(out_pkt_in_evt)) & ~$past(pwdata[7:0]))))
    else $error("write zero changed an out flag");

  // a source read clears the flag it named and nothing else
  AST_SRC_RDCLR_IN0: assert property ((rd_fire && src_rd_q && !in_pkt_out_evt[0]
    && prdata_q[7:0] == `UBEIRQ_CODE_IN0) |=> !in_flag_q[0])
    else $error("source read did not clear in0 flag");

  AST_SRC_RDCLR_ONE: assert property ((rd_fire && src_rd_q && prdata_q[7:0] == `UBEIRQ_CODE_OUT0)
    |=> ((out_flag_q[7:1] & $past(out_flag_q[7:1])) == $past(out_flag_q[7:1])))
    else $error("source read cleared a flag it did not name");

  AST_SRC_NONE_KEEP: assert property ((rd_fire && src_rd_q && prdata_q[7:0] == `UBEIRQ_CODE_NONE)
    |=> ((out_flag_q & $past(out_flag_q)) == $past(out_flag_q)
         && (in_flag_q & $past(in_flag_q)) == $past(in_flag_q)))
    else $error("empty source read cleared a flag");

  // endpoint zero requests only with flag, enable and gate together
  AST_OUT0_REQ: assert property ((out_flag_q[0] && out_en_q[0] && out_gate_q) |-> usb_irq)
    else $error("out0 with enable and gate raised no request");

  AST_IN0_REQ: assert property ((in_flag_q[0] && in_en_q[0] && in_gate_q) |-> usb_irq)
    else $error("in0 with enable and gate raised no request");

  AST_OUT0_NO_GATE: assert property ((!out_gate_q && out_en_q[7:1] == 7'h00 && in_en_q == 8'h00)
    |-> !usb_irq)
    else $error("out0 requested with its gate clear");

  // an enabled endpoint raises the line the cycle after its packet event
  AST_IRQ_NEXT: assert property ((out_pkt_in_evt[2] && out_en_q[2] && !(wr_fire && hit_out_en))
    |=> usb_irq)
    else $error("enabled packet event raised no request");

  // enable and gate storage moves only on its own write
  AST_OUT_EN_STORE: assert property ((wr_fire && hit_out_en) |=> out_en_q == $past(pwdata[7:0]))
    else $error("out enable write not stored");

  AST_EN_HOLD: assert property (!(wr_fire && (hit_out_en || hit_in_en))
    |=> (out_en_q == $past(out_en_q) && in_en_q == $past(in_en_q)))
    else $error("enable changed without its write");

  AST_OUT_GATE_STORE: assert property ((wr_fire && hit_out_cfg)
    |=> out_gate_q == $past(pwdata[`UBEIRQ_GATE_BIT]))
    else $error("out gate write not stored");

  AST_IN_GATE_STORE: assert property ((wr_fire && hit_in_cfg)
    |=> in_gate_q == $past(pwdata[`UBEIRQ_GATE_BIT]))
    else $error("in gate write not stored");

  AST_IN_SEP_DIR: assert property ((wr_fire && hit_in_flags)
    |=> ((out_flag_q & $past(out_flag_q)) == $past(out_flag_q)))
    else $error("in flag write touched out flags");

  // bus answers: an error only for unmapped words, writes leave read data clear
  AST_SLVERR: assert property ((setup_ph && !mapped) ##1 access_ph |-> pslverr)
    else $error("unmapped access gave no error");

  AST_NO_SLVERR: assert property ((setup_ph && mapped) ##1 access_ph |-> !pslverr)
    else $error("mapped access gave an error");

  AST_WR_RDATA: assert property ((setup_ph && pwrite) |=> prdata_q == 32'h00000000)
    else $error("write left read data behind");

  AST_UNMAPPED_WR: assert property ((wr_fire && !mapped)
    |=> (out_gate_q == $past(out_gate_q) && in_gate_q == $past(in_gate_q)))
    else $error("unmapped write changed a gate");

  CVR_SRC_READ: cover property (rd_fire && src_rd_q && prdata_q[7:0] != `UBEIRQ_CODE_NONE);
  CVR_IRQ_RISE: cover property (!usb_irq ##1 usb_irq);
  CVR_SET_CLR: cover property (wr_fire && hit_out_flags && |(pwdata[7:0] & out_pkt_in_evt));
  CVR_EP0_IRQ: cover property (out_req[0] && usb_irq);
  CVR_SRC_NONE: cover property (rd_fire && src_rd_q && prdata_q[7:0] == `UBEIRQ_CODE_NONE);
endmodule : ubeirq_top

/* File: tb/ubeirq_cpu_model.sv */
`timescale 1ns/100ps
module ubeirq_cpu_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic usb_irq,
  output logic [7:0] irq_edges_q
);
  logic irq_seen_q;

  // cpu side of the single request line: counts each new request so the bench
  // can tell one merged line from a line that chatters or never drops
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_seen_q <= 1'b0;
      irq_edges_q <= 8'h00;
    end
    else
    begin
      irq_seen_q <= usb_irq;
      if (usb_irq && !irq_seen_q)
      begin
        irq_edges_q <= irq_edges_q + 8'h01;
      end
    end
  end
endmodule : ubeirq_cpu_model

/* File: tb/usb_endpoint_irq_flags_enables_tb.sv */
`timescale 1ns/100ps
`include "ubeirq_cfg.svh"
module usb_endpoint_irq_flags_enables_tb;
  import ubeirq_pkg::*;
  typedef struct packed {logic [7:0] oen; logic [7:0] ien; logic og; logic ig;
    logic [7:0] oev; logic [7:0] iev; logic irq;} ubeirq_row_t;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, usb_irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  ubeirq_vec_t out_pkt_in_evt, in_pkt_out_evt;
  logic [7:0] irq_edges, n_irq;
  logic [7:0] codes [5];
  ubeirq_row_t rows [8];
  int fail_count, n_compared;

  ubeirq_top i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_pkt_in_evt(out_pkt_in_evt), .in_pkt_out_evt(in_pkt_out_evt), .usb_irq(usb_irq));
  ubeirq_cpu_model i_cpu (.clk(clk), .sys_rst(sys_rst), .usb_irq(usb_irq), .irq_edges_q(irq_edges));

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; holds everything until pready is seen, then idles a cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    r = prdata;
    e = pslverr;
    if (k >= 50)
      fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // reserved upper bits always go out as zero
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr

  // one-cycle packet events, then one cycle for the flags to land
  task automatic pulse(input logic [7:0] o, input logic [7:0] i);
    out_pkt_in_evt <= o;
    in_pkt_out_evt <= i;
    @(posedge clk);
    out_pkt_in_evt <= 8'h00;
    in_pkt_out_evt <= 8'h00;
    @(posedge clk);
  endtask : pulse

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    out_pkt_in_evt = 8'h00;
    in_pkt_out_evt = 8'h00;
    n_irq = 8'h00;
    rows[0] = '{8'h00, 8'h00, 1'b0, 1'b0, 8'h04, 8'h00, 1'b0};
    rows[1] = '{8'h04, 8'h00, 1'b0, 1'b0, 8'h04, 8'h00, 1'b1};
    rows[2] = '{8'h00, 8'h80, 1'b0, 1'b0, 8'h00, 8'h80, 1'b1};
    rows[3] = '{8'h01, 8'h00, 1'b0, 1'b1, 8'h01, 8'h00, 1'b0};
    rows[4] = '{8'h01, 8'h00, 1'b1, 1'b0, 8'h01, 8'h00, 1'b1};
    rows[5] = '{8'h00, 8'h01, 1'b0, 1'b1, 8'h00, 8'h01, 1'b1};
    rows[6] = '{8'hFE, 8'hFE, 1'b1, 1'b1, 8'h01, 8'h01, 1'b0};
    rows[7] = '{8'h00, 8'h02, 1'b1, 1'b1, 8'h02, 8'h00, 1'b0};
    codes = '{`UBEIRQ_CODE_OUT0, `UBEIRQ_CODE_IN0, `UBEIRQ_CODE_OUT_BASE + 8'h04, `UBEIRQ_CODE_IN_BASE + 8'h02,
      `UBEIRQ_CODE_NONE};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // gating table: enables and endpoint-0 gates set before the event
    foreach (rows[i])
    begin
      wr(`UBEIRQ_OFS_OUT_EN, rows[i].oen);
      wr(`UBEIRQ_OFS_IN_EN, rows[i].ien);
      wr(`UBEIRQ_OFS_OUT_CFG0, {7'h00, rows[i].og});
      wr(`UBEIRQ_OFS_IN_CFG0, {7'h00, rows[i].ig});
      pulse(rows[i].oev, rows[i].iev);
      chk({31'h0, usb_irq}, {31'h0, rows[i].irq});
      apb(1'b0, `UBEIRQ_OFS_OUT_FLAGS, 32'h0);
      chk(r, {24'h000000, rows[i].oev});
      apb(1'b0, `UBEIRQ_OFS_IN_FLAGS, 32'h0);
      chk(r, {24'h000000, rows[i].iev});
      wr(`UBEIRQ_OFS_OUT_FLAGS, 8'hFF);
      wr(`UBEIRQ_OFS_IN_FLAGS, 8'hFF);
      chk({31'h0, usb_irq}, 32'h0);
      n_irq = n_irq + {7'h00, rows[i].irq};
    end
    chk({24'h000000, irq_edges}, {24'h000000, n_irq});
    // four sources pending at once: served in code order, each read clears one
    wr(`UBEIRQ_OFS_OUT_EN, 8'hFF);
    wr(`UBEIRQ_OFS_IN_EN, 8'hFF);
    pulse(8'h05, 8'h03);
    foreach (codes[i])
    begin
      apb(1'b0, `UBEIRQ_OFS_SRC, 32'h0);
      chk(r, {24'h000000, codes[i]});
    end
    apb(1'b0, `UBEIRQ_OFS_OUT_FLAGS, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, usb_irq}, 32'h0);
    // partial write-one-to-clear in both directions, out requests masked
    wr(`UBEIRQ_OFS_OUT_EN, 8'h00);
    pulse(8'h0F, 8'h0C);
    wr(`UBEIRQ_OFS_OUT_FLAGS, 8'h05);
    apb(1'b0, `UBEIRQ_OFS_OUT_FLAGS, 32'h0);
    chk(r, 32'h0000000A);
    wr(`UBEIRQ_OFS_IN_FLAGS, 8'h04);
    apb(1'b0, `UBEIRQ_OFS_IN_FLAGS, 32'h0);
    chk(r, 32'h00000008);
    chk({31'h0, usb_irq}, 32'h1);
    wr(`UBEIRQ_OFS_IN_EN, 8'hA5);
    apb(1'b0, `UBEIRQ_OFS_IN_EN, 32'h0);
    chk(r, 32'h000000A5);
    chk({31'h0, usb_irq}, 32'h0);
    // unmapped address, read and write
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, 12'h01C, 32'h000000FF);
    chk({31'h0, e}, 32'h1);
    // mid-run reset with flags and enables live
    pulse(8'h80, 8'h81);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, usb_irq}, 32'h0);
    for (int a = 0; a < 24; a += 4)
    begin
      apb(1'b0, 12'(a), 32'h0);
      chk(r, 32'h0);
    end
    test_done();
  end
endmodule : usb_endpoint_irq_flags_enables_tb
